// file: common/cqm_pkg.sv
// cqm_pkg: shared constants and carriers of the cascade four_way_switch control
// assumes: one 100 MHz clock, stream words of 16 bits
`default_nettype none

package cqm_pkg;

    // =========================================================
    // boundary channel id layout
    localparam int ID_LINE_MSB = 15;
    localparam int ID_LINE_LSB = 7;
    localparam int ID_FIELD_BIT = 6;
    localparam int ID_REGION_BIT = 5;
    localparam int ID_ANALOG_BIT = 4;
    localparam int ID_STAGE_MSB = 3;
    localparam int ID_STAGE_LSB = 2;
    localparam int ID_PATH_MSB = 1;
    localparam int ID_PATH_LSB = 0;

    // =========================================================
    // queue and period sizes
    localparam int SHARED_QUEUE_DEPTH = 128;
    localparam int QUADS = 4;
    localparam int QUEUE_DEPTH = SHARED_QUEUE_DEPTH / QUADS;
    localparam int PERIOD_MAX = 1024;
    localparam int PERIOD_W = $clog2(PERIOD_MAX);
    localparam logic [1:0] MASTER_STAGE = 2'h0;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // =========================================================
    // modes and carriers
    typedef enum logic [1:0] {
        CQM_LIVE = 2'b00,
        CQM_STROBE = 2'b01,
        CQM_SWITCH = 2'b10
    } cqm_mode_t;

    typedef struct packed {
        logic [1:0] stage;
        logic [1:0] chan;
    } cqm_entry_t;

    typedef struct packed {
        cqm_entry_t lt;
        cqm_entry_t rt;
        cqm_entry_t lb;
        cqm_entry_t rb;
    } cqm_quad_t;

    typedef struct packed {
        logic [15:0] data;
        logic hs;
        logic vs;
        logic popup;
        logic [1:0] zoom;
        logic box;
        cqm_entry_t sw;
    } cqm_word_t;

endpackage

`default_nettype wire

// file: design/cqm_buf2.sv
// cqm_buf2: two-entry stream buffer, valid/ready on both sides
// assumes: source and sink on the same clock
`default_nettype none

module cqm_buf2 (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic s_valid,
    output logic s_ready,
    input wire cqm_pkg::cqm_word_t s_data,
    output logic m_valid,
    input wire logic m_ready,
    output cqm_pkg::cqm_word_t m_data
);

    // =========================================================
    // head slot drives the sink, second slot absorbs a stall
    cqm_pkg::cqm_word_t slot1_r;
    logic v1_r;
    logic pop;
    logic push;

    assign pop = m_valid & m_ready;
    assign push = s_valid & s_ready;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            m_valid <= 1'b0;
            v1_r <= 1'b0;
            s_ready <= 1'b1;
            m_data <= '0;
            slot1_r <= '0;
        end else begin
            if (pop && v1_r) begin
                m_data <= slot1_r;
                slot1_r <= s_data;
                v1_r <= push;
                s_ready <= !push;
            end else if (pop) begin
                m_data <= s_data;
                m_valid <= push;
            end else if (push && !m_valid) begin
                m_data <= s_data;
                m_valid <= 1'b1;
            end else if (push) begin
                slot1_r <= s_data;
                v1_r <= 1'b1;
                s_ready <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// file: design/cqm_sync3.sv
// cqm_sync3: three-stage input synchroniser with agreement filter
// assumes: inputs asynchronous to clock
`default_nettype none

module cqm_sync3 #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_r
);

    // =========================================================
    // three flops, change taken when second and third agree
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            level_r <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    level_r[i] <= s3_r[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: design/cqm_top.sv
// cqm_top: cascade link merge, boundary id and four-way switch queue
// assumes: stream inputs and control bits on clock; trigger pin async
`default_nettype none

module cqm_top #(
    parameter int QDEPTH = cqm_pkg::QUEUE_DEPTH
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic boundary_id_enable,
    input wire logic position_control_enable,
    input wire logic [1:0] function_mode_select,
    input wire logic trigger_source_select,
    input wire logic position_interrupt_trigger,
    input wire logic [7:0] picture_position,
    input wire logic [$clog2(QDEPTH)-1:0] queue_length,
    input wire logic [$clog2(QDEPTH)-1:0] queue_entry_address,
    input wire cqm_pkg::cqm_quad_t queue_channel_entry,
    input wire logic queue_write_set,
    output logic queue_write_strobe,
    input wire logic [cqm_pkg::PERIOD_W-1:0] switch_period_count,
    input wire logic period_unit_select,
    input wire logic field_counter_reset_set,
    output logic field_counter_reset,
    input wire logic queue_pointer_reset_set,
    output logic queue_pointer_reset,
    input wire logic strobe_field_select,
    input wire logic strobe_auto_update,
    output logic strobe_capture_r,
    input wire logic [1:0] cascade_stage,
    input wire logic link_enable_display,
    input wire logic link_enable_record,
    input wire logic last_stage_display,
    input wire logic last_stage_record,
    input wire logic infinite_cascade_enable,
    input wire logic external_trigger_pin,
    input wire logic field_start,
    input wire logic field_odd,
    input wire logic local_valid,
    output logic local_ready,
    input wire cqm_pkg::cqm_word_t local_word,
    input wire logic local_active,
    input wire logic local_boundary,
    input wire logic [8:0] active_line_index,
    input wire logic analog_switch_flag,
    input wire logic [1:0] input_path_number,
    input wire logic chain_valid,
    input wire cqm_pkg::cqm_word_t chain_data_input,
    input wire logic chain_vsync_input,
    input wire logic chain_hsync_input,
    output logic [15:0] video_data_output,
    output logic encoder_vsync_output,
    output logic encoder_hsync_output,
    output logic video_out_valid,
    input wire logic video_out_ready,
    output logic final_output_owner_r,
    output cqm_pkg::cqm_quad_t quad_layout_r,
    output logic layout_from_queue_r,
    output cqm_pkg::cqm_entry_t current_switch_channel,
    output logic [1:0] multipurpose_pins
);

    localparam int AW = $clog2(QDEPTH);

    // =========================================================
    // boundary id and chain merge
    cqm_pkg::cqm_word_t merged;
    cqm_pkg::cqm_word_t out_word;
    logic [15:0] id_word;
    logic chain_accept;
    logic pick_chain;
    logic buf_ready;
    logic push;

    always_comb begin
        id_word = cqm_pkg::WORD_RESET;
        id_word[cqm_pkg::ID_LINE_MSB:cqm_pkg::ID_LINE_LSB] = active_line_index;
        id_word[cqm_pkg::ID_FIELD_BIT] = field_odd;
        id_word[cqm_pkg::ID_REGION_BIT] = local_active;
        id_word[cqm_pkg::ID_ANALOG_BIT] = analog_switch_flag;
        id_word[cqm_pkg::ID_STAGE_MSB:cqm_pkg::ID_STAGE_LSB] = cascade_stage;
        id_word[cqm_pkg::ID_PATH_MSB:cqm_pkg::ID_PATH_LSB] = input_path_number;
    end

    assign chain_accept = chain_valid && link_enable_display &&
        (!last_stage_display || infinite_cascade_enable);

    // master popup over slave popup over rest
    always_comb begin
        pick_chain = 1'b0;
        if (chain_accept) begin
            if (!local_active) begin
                pick_chain = 1'b1;
            end else if (!local_word.popup && chain_data_input.popup) begin
                pick_chain = 1'b1;
            end
        end
    end

    // id replaces boundary word only when enabled
    always_comb begin
        merged = local_word;
        if (local_boundary && boundary_id_enable) begin
            merged.data = id_word;
        end
        if (pick_chain) begin
            merged = chain_data_input;
        end
        merged.hs = chain_accept ? chain_hsync_input : local_word.hs;
        merged.vs = chain_accept ? chain_vsync_input : local_word.vs;
        merged.sw = current_switch_channel;
    end

    assign push = local_valid && buf_ready;
    assign local_ready = buf_ready;

    cqm_buf2 u_buf (
        .clock(clock),
        .sys_rst(sys_rst),
        .s_valid(local_valid),
        .s_ready(buf_ready),
        .s_data(merged),
        .m_valid(video_out_valid),
        .m_ready(video_out_ready),
        .m_data(out_word)
    );

    assign video_data_output = out_word.data;
    assign encoder_vsync_output = out_word.vs;
    assign encoder_hsync_output = out_word.hs;

    // final output owner is the master stage, or any stage with infinite cascade enabled
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            final_output_owner_r <= 1'b0;
        end else begin
            final_output_owner_r <= (cascade_stage == cqm_pkg::MASTER_STAGE) ||
                infinite_cascade_enable;
        end
    end

    // =========================================================
    // self-clearing control bits
    // write bit set wins, clears after store
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            queue_write_strobe <= 1'b0;
        end else if (queue_write_set) begin
            queue_write_strobe <= 1'b1;
        end else if (queue_write_strobe) begin
            queue_write_strobe <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            field_counter_reset <= 1'b0;
        end else if (field_counter_reset_set) begin
            field_counter_reset <= 1'b1;
        end else if (field_counter_reset) begin
            field_counter_reset <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            queue_pointer_reset <= 1'b0;
        end else if (queue_pointer_reset_set) begin
            queue_pointer_reset <= 1'b1;
        end else if (queue_pointer_reset) begin
            queue_pointer_reset <= 1'b0;
        end
    end

    // =========================================================
    // queue storage, shared-size limit
    cqm_pkg::cqm_quad_t queue_r [QDEPTH];

    // thirty-two entry store, write on strobe
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < QDEPTH; i++) begin
                queue_r[i] <= '0;
            end
        end else if (queue_write_strobe) begin
            queue_r[queue_entry_address] <= queue_channel_entry;
        end
    end

    // =========================================================
    // triggers and period counter
    logic ext_level;
    logic ext_prev_r;
    logic unit_tick;
    logic advance;
    logic [cqm_pkg::PERIOD_W-1:0] fcnt_r;
    logic [AW-1:0] ptr_r;
    logic [AW-1:0] ptr_nxt;

    cqm_sync3 #(.W(1)) u_trig (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_in(external_trigger_pin),
        .level_r(ext_level)
    );

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ext_prev_r <= 1'b0;
        end else begin
            ext_prev_r <= ext_level;
        end
    end

    // frame unit ticks at odd field start
    assign unit_tick = field_start && (!period_unit_select || field_odd);

    // zero external edge, one internal period
    always_comb begin
        if (trigger_source_select) begin
            advance = unit_tick && (fcnt_r == switch_period_count);
        end else begin
            advance = ext_level && !ext_prev_r;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fcnt_r <= '0;
        end else if (field_counter_reset) begin
            fcnt_r <= '0;
        end else if (trigger_source_select && unit_tick) begin
            if (fcnt_r == switch_period_count) begin
                fcnt_r <= '0;
            end else begin
                fcnt_r <= fcnt_r + 1'b1;
            end
        end
    end

    assign ptr_nxt = (ptr_r == queue_length) ? '0 : AW'(ptr_r + 1'b1);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_r <= '0;
        end else if (queue_pointer_reset) begin
            ptr_r <= '0;
        end else if (advance) begin
            ptr_r <= ptr_nxt;
        end
    end

    // =========================================================
    // layout selection
    cqm_pkg::cqm_quad_t pos_quad;
    cqm_pkg::cqm_quad_t switch_quad_r;
    cqm_pkg::cqm_entry_t slot [4];
    logic use_queue;

    // layout from picture position per quadrant
    always_comb begin
        for (int q = 0; q < 4; q++) begin
            slot[q] = '0;
            for (int c = 0; c < 4; c++) begin
                if (picture_position[2*c +: 2] == 2'(q)) begin
                    slot[q] = '{stage: cascade_stage, chan: 2'(c)};
                end
            end
        end
        pos_quad = '{lt: slot[0], rt: slot[1], lb: slot[2], rb: slot[3]};
    end

    // queue drives layout in switch mode or with position control enabled
    assign use_queue = position_control_enable ||
        (cqm_pkg::cqm_mode_t'(function_mode_select) == cqm_pkg::CQM_SWITCH);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            switch_quad_r <= '0;
        end else if (position_interrupt_trigger) begin
            switch_quad_r <= queue_channel_entry;
        end else if (advance) begin
            switch_quad_r <= queue_r[ptr_nxt];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            quad_layout_r <= '0;
            layout_from_queue_r <= 1'b0;
        end else begin
            quad_layout_r <= use_queue ? switch_quad_r : pos_quad;
            layout_from_queue_r <= use_queue;
        end
    end

    // =========================================================
    // auto strobe on switch
    logic strobe_pending_r;

    // capture the selected field after a switch, in field units only
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            strobe_pending_r <= 1'b0;
            strobe_capture_r <= 1'b0;
        end else begin
            strobe_capture_r <= 1'b0;
            if (advance && !period_unit_select) begin
                strobe_pending_r <= 1'b1;
            end else if (strobe_pending_r && field_start &&
                    field_odd == strobe_field_select) begin
                strobe_pending_r <= 1'b0;
                strobe_capture_r <= strobe_auto_update;
            end
        end
    end

    // =========================================================
    // current switch channel readout
    // record chain channel or own, pins on last
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            current_switch_channel <= '0;
            multipurpose_pins <= 2'h0;
        end else begin
            if (link_enable_record && !last_stage_record && chain_valid) begin
                current_switch_channel <= chain_data_input.sw;
            end else begin
                current_switch_channel <= switch_quad_r.lt;
            end
            multipurpose_pins <= last_stage_record ? switch_quad_r.lt.chan : 2'h0;
        end
    end

    // =========================================================
    // checks
    boundary_id_fmt_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        push && local_boundary && boundary_id_enable && !pick_chain |->
        merged.data == {active_line_index, field_odd, local_active,
            analog_switch_flag, cascade_stage, input_path_number})
        else $error("boundary id layout wrong");

    boundary_id_off_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        push && !boundary_id_enable && !pick_chain |->
        merged.data == local_word.data)
        else $error("id inserted while disabled");

    chain_gate_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !link_enable_display |-> !pick_chain)
        else $error("chain data taken without link enable");

    master_popup_wins_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        local_active && local_word.popup |-> !pick_chain)
        else $error("master popup lost to slave");

    queue_write_done_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        queue_write_strobe && !queue_write_set |=>
        !queue_write_strobe &&
        queue_r[$past(queue_entry_address)] == $past(queue_channel_entry))
        else $error("queue write not stored or not cleared");

    counter_reset_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        field_counter_reset && !field_counter_reset_set |=>
        fcnt_r == '0 && !field_counter_reset)
        else $error("field counter not reset");

    pointer_reset_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        queue_pointer_reset && !queue_pointer_reset_set |=>
        ptr_r == '0 && !queue_pointer_reset)
        else $error("queue pointer not reset");

    period_count_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        trigger_source_select && unit_tick && !field_counter_reset &&
        fcnt_r != switch_period_count |=>
        fcnt_r == cqm_pkg::PERIOD_W'($past(fcnt_r) + 1'b1))
        else $error("period counter did not step");

    layout_source_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !use_queue |=> quad_layout_r == $past(pos_quad) && !layout_from_queue_r)
        else $error("layout not from picture position");

    last_stage_pins_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        last_stage_record |=> multipurpose_pins == $past(switch_quad_r.lt.chan))
        else $error("switch channel missing on pins");

endmodule

`default_nettype wire

// file: verification/cqm_chain_model.sv
// cqm_chain_model: lower slave chip on the chain link
// assumes: same clock as the master, bench raises send around a take
`default_nettype none
module cqm_chain_model (
    input wire logic clock,
    input wire logic send,
    input wire cqm_pkg::cqm_word_t word,
    output logic chain_valid,
    output cqm_pkg::cqm_word_t chain_data_input,
    output logic chain_vsync_input,
    output logic chain_hsync_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // link drive
    // slave forwards word
    always @(negedge clock) begin
        chain_valid = send;
        chain_data_input = send ? word : ~word;
        chain_vsync_input = send & word.vs;
        chain_hsync_input = send & word.hs;
    end
endmodule
`default_nettype wire

// file: verification/tb_cascade_four_way_switch_control.sv
// tb_cascade_four_way_switch_control: self-checking bench of cqm_top
// assumes: inputs change at the falling edge, chain model on the link
`default_nettype none
module tb_cascade_four_way_switch_control;
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================================
    // signals
    logic clock = 1'b0, sys_rst = 1'b1, boundary_id_enable, position_control_enable;
    logic trigger_source_select, position_interrupt_trigger, queue_write_set, queue_write_strobe;
    logic period_unit_select, field_counter_reset_set, field_counter_reset, strobe_capture_r;
    logic queue_pointer_reset_set, queue_pointer_reset, strobe_field_select, strobe_auto_update;
    logic link_enable_display, link_enable_record, last_stage_display, last_stage_record;
    logic infinite_cascade_enable, external_trigger_pin, field_start, field_odd, local_valid;
    logic local_ready, local_active, local_boundary, analog_switch_flag, chain_valid, send;
    logic chain_vsync_input, chain_hsync_input, encoder_vsync_output, encoder_hsync_output;
    logic video_out_valid, video_out_ready, final_output_owner_r, layout_from_queue_r;
    logic [1:0] function_mode_select, cascade_stage, input_path_number, multipurpose_pins;
    logic [7:0] picture_position;
    logic [4:0] queue_length, queue_entry_address;
    logic [9:0] switch_period_count;
    logic [8:0] active_line_index;
    logic [15:0] video_data_output;
    cqm_pkg::cqm_quad_t queue_channel_entry, quad_layout_r;
    cqm_pkg::cqm_word_t local_word, chain_data_input, word;
    cqm_pkg::cqm_entry_t current_switch_channel;
    int checks = 0, miscompares = 0;
    cqm_top cqm_top_inst (.*);
    cqm_chain_model cqm_chain_model_inst (.*);
    initial forever #5 clock = ~clock;
    // =========================================================
    // checking
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic expired(input int n);
        if (n >= 40) begin
            miscompares++;
            complete_run();
        end
    endtask
    // =========================================================
    // scenarios
    task automatic xfer(input logic [15:0] exp);
        int n;
        local_valid = 1'b1;
        for (n = 0; n < 40 && local_ready !== 1'b1; n++) @(negedge clock);
        expired(n);
        @(negedge clock);
        local_valid = 1'b0;
        for (n = 0; n < 40 && video_out_valid !== 1'b1; n++) @(negedge clock);
        expired(n);
        chk(video_data_output, exp);
        @(negedge clock);
    endtask
    task automatic boundary_case();
        {active_line_index, field_odd, analog_switch_flag} = {9'h1a5, 2'h3};
        {cascade_stage, input_path_number, local_word.data} = {2'h2, 2'h3, 16'hbeef};
        for (int k = 0; k < 3; k++) begin
            boundary_id_enable = (k != 0);
            local_boundary = (k != 2);
            xfer(k == 1 ? 16'hd2fb : 16'hbeef);
        end
        chk({15'h0000, final_output_owner_r}, 16'h0000);
        chk(quad_layout_r, 16'h89ab);
        infinite_cascade_enable = 1'b1;
        repeat (2) @(negedge clock);
        chk({15'h0000, final_output_owner_r}, 16'h0001);
        {boundary_id_enable, infinite_cascade_enable, cascade_stage} = 4'h0;
    endtask
    task automatic chain_case();
        logic [2:0] cs [4] = '{3'h4, 3'h5, 3'h0, 3'h6};
        {send, word.data, word.popup, local_word.data} = {1'b1, 16'h2222, 1'b1, 16'h1111};
        {link_enable_record, word.sw} = 5'h19;
        @(negedge clock);
        for (int k = 0; k < 4; k++) begin
            {link_enable_display, last_stage_display, local_word.popup} = cs[k];
            xfer(cs[k] == 3'h4 ? 16'h2222 : 16'h1111);
        end
        chk({12'h000, current_switch_channel}, 16'h0009);
        {send, link_enable_record} = 2'h0;
    endtask
    task automatic buffer_case();
        int got = 0;
        video_out_ready = 1'b0;
        local_valid = 1'b1;
        for (int i = 0; i < 4; i++) begin
            local_word.data = 16'h00a0 + 16'(got);
            got += (local_ready === 1'b1);
            @(negedge clock);
        end
        local_valid = 1'b0;
        chk(16'(got), 16'h0002);
        video_out_ready = 1'b1;
        for (int j = 0; j < 2; j++) begin
            chk({video_out_valid, video_data_output[14:0]}, 16'h80a0 + 16'(j));
            @(negedge clock);
        end
    endtask
    task automatic selfclr(input int k);
        {queue_write_set, field_counter_reset_set, queue_pointer_reset_set} = 3'h4 >> k;
        @(negedge clock);
        {queue_write_set, field_counter_reset_set, queue_pointer_reset_set} = 3'h0;
        chk({13'h0000, queue_write_strobe, field_counter_reset, queue_pointer_reset},
            16'h0004 >> k);
        @(negedge clock);
        chk({13'h0000, queue_write_strobe, field_counter_reset, queue_pointer_reset},
            16'h0000);
    endtask
    task automatic advance(input logic [15:0] prev);
        int n;
        for (n = 0; n < 40 && quad_layout_r === prev; n++) @(negedge clock);
        expired(n);
    endtask
    task automatic switch_case();
        logic [15:0] first;
        {position_control_enable, function_mode_select, last_stage_record} = 4'hb;
        {strobe_auto_update, strobe_field_select} = 2'h3;
        {position_interrupt_trigger, queue_channel_entry} = {1'b1, 16'h1234};
        @(negedge clock);
        position_interrupt_trigger = 1'b0;
        repeat (2) @(negedge clock);
        chk(quad_layout_r, 16'h1234);
        chk({10'h000, current_switch_channel, multipurpose_pins}, 16'h0005);
        {queue_entry_address, queue_channel_entry} = {5'h00, 16'h5a5a};
        selfclr(0);
        {queue_entry_address, queue_channel_entry, queue_length} = {5'h01, 16'h3c3c, 5'h01};
        selfclr(0);
        selfclr(1);
        selfclr(2);
        {trigger_source_select, field_start} = 2'h3;
        @(negedge clock);
        field_start = 1'b0;
        advance(16'h1234);
        first = quad_layout_r;
        chk(first, 16'h3c3c);
        trigger_source_select = 1'b0;
        field_start = 1'b1;
        @(negedge clock);
        field_start = 1'b0;
        chk({15'h0000, strobe_capture_r}, 16'h0001);
        {trigger_source_select, external_trigger_pin} = 2'h1;
        advance(first);
        chk(quad_layout_r, 16'h5a5a);
        chk({15'h0000, layout_from_queue_r}, 16'h0001);
    endtask
    // =========================================================
    // main sequence
    initial begin
        {boundary_id_enable, position_control_enable, function_mode_select,
         trigger_source_select, position_interrupt_trigger, picture_position, queue_length,
         queue_entry_address, queue_channel_entry, queue_write_set, switch_period_count,
         period_unit_select, field_counter_reset_set, queue_pointer_reset_set,
         strobe_field_select, strobe_auto_update, cascade_stage, link_enable_display,
         link_enable_record, last_stage_display, last_stage_record, infinite_cascade_enable,
         external_trigger_pin, field_start, field_odd, local_valid, local_word,
         local_boundary, active_line_index, analog_switch_flag, input_path_number,
         send, word} = '0;
        {local_active, video_out_ready} = 2'h3;
        picture_position = 8'he4;
        repeat (8) @(negedge clock);
        sys_rst = 1'b0;
        @(negedge clock);
        boundary_case();
        chain_case();
        buffer_case();
        switch_case();
        complete_run();
    end
endmodule
`default_nettype wire
